// ---- verilog/init_irq_pkg.sv ----
// ==========================================================================
// shared constants for the register port and the mask / address bank
package init_irq_pkg;

  // ========================================================================
  // widths of the register port
  localparam int DATA_W = 16;
  localparam int IDX_W = 7;
  localparam int EV_N = 6;

  // ========================================================================
  // register indices loaded into the index port
  localparam logic [6:0] IDX_STATUS = 7'h00;       // read-only view of flags
  localparam logic [6:0] IDX_ADDR_LOW = 7'h01;     // init_block_address_low
  localparam logic [6:0] IDX_ADDR_HIGH = 7'h02;    // init_block_address_high
  localparam logic [6:0] IDX_MASKS = 7'h03;        // interrupt_masks_and_deferral
  localparam logic [6:0] IDX_SHADOW_LOW = 7'h10;   // init_addr_low_shadow
  localparam logic [6:0] IDX_SHADOW_HIGH = 7'h11;  // init_addr_high_shadow
  localparam logic [6:0] IDX_RESET_REG = 7'h14;    // reading it clears recovery

  // ========================================================================
  // field positions inside the 16-bit words
  localparam int POS_BABBLE = 14;
  localparam int POS_MISSED = 12;
  localparam int POS_MEMERR = 11;
  localparam int POS_RX_DONE = 10;
  localparam int POS_TX_DONE = 9;
  localparam int POS_INIT_DONE = 8;
  localparam int POS_TX_FIFO_UNDERFLOW_ERROR_RECOVER = 6;
  localparam int POS_SUMMARY = 7;
  localparam int POS_IRQ_EN = 6;
  localparam int POS_TX_ON = 4;
  localparam int POS_SUSPEND = 3;
  localparam int POS_STOP = 2;

  // ========================================================================
  // order of the six events inside an event vector
  localparam int EV_INIT_DONE = 0;
  localparam int EV_TX_DONE = 1;
  localparam int EV_RX_DONE = 2;
  localparam int EV_MEMERR = 3;
  localparam int EV_MISSED = 4;
  localparam int EV_BABBLE = 5;

  // ========================================================================
  // values after reset
  localparam logic [5:0] MASKS_RESET = 6'h00;
  localparam logic TX_FIFO_UNDERFLOW_ERROR_RECOVER_RESET = 1'b0;
  localparam logic [6:0] INDEX_RESET = 7'h00;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

  typedef logic [5:0] event_vec_t;

  // host sequencer states, one-hot
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_INDEX = 4'h2,
    H_ACCESS = 4'h4,
    H_WAIT = 4'h8
  } host_state_t;

  // spreads an event vector onto its bit positions of a 16-bit word
  function automatic logic [15:0] place_events(input event_vec_t v);
    logic [15:0] w;
    w = 16'h0000;
    w[POS_INIT_DONE] = v[EV_INIT_DONE];
    w[POS_TX_DONE] = v[EV_TX_DONE];
    w[POS_RX_DONE] = v[EV_RX_DONE];
    w[POS_MEMERR] = v[EV_MEMERR];
    w[POS_MISSED] = v[EV_MISSED];
    w[POS_BABBLE] = v[EV_BABBLE];
    return w;
  endfunction : place_events

  // gathers an event vector back from its bit positions
  function automatic event_vec_t pick_events(input logic [15:0] w);
    event_vec_t v;
    v = 6'h00;
    v[EV_INIT_DONE] = w[POS_INIT_DONE];
    v[EV_TX_DONE] = w[POS_TX_DONE];
    v[EV_RX_DONE] = w[POS_RX_DONE];
    v[EV_MEMERR] = w[POS_MEMERR];
    v[EV_MISSED] = w[POS_MISSED];
    v[EV_BABBLE] = w[POS_BABBLE];
    return v;
  endfunction : pick_events

endpackage : init_irq_pkg

// ---- verilog/reg_port_if.sv ----
`timescale 1ns/1ps
// ==========================================================================
// register port between host software engine and the register bank
interface reg_port_if;
  logic index_wr;                 // one-cycle pulse: wdata low bits -> index
  logic data_wr;                  // one-cycle pulse: write selected register
  logic data_rd;                  // one-cycle pulse: read selected register
  logic [15:0] wdata;             // write data / index value
  logic [15:0] rdata;             // read data
  logic rdata_valid;              // one-cycle pulse with rdata

  modport host (
    output index_wr,
    output data_wr,
    output data_rd,
    output wdata,
    input rdata,
    input rdata_valid
  );

  modport device (
    input index_wr,
    input data_wr,
    input data_rd,
    input wdata,
    output rdata,
    output rdata_valid
  );
endinterface : reg_port_if

// ---- verilog/init_irq_regs.sv ----
`timescale 1ns/1ps
// Behaviour
// RL1: low address holds bits 15-0, bit0 zero
// RL2: low write also copies into low shadow
// RL3: address registers accessible only when stopped/suspended
// RL4: high address bits 23-16; upper byte zero
// RL5: high write also copies into high shadow
// RL6: babble mask blocks summary, flag still kept
// RL7: missed mask blocks missed-frame summary contribution
// RL8: memory-error mask blocks memory-error summary contribution
// RL9: receive mask blocks receive-done summary contribution
// RL10: transmit mask at bit 9 blocks
// RL11: init-done mask at bit 8 blocks
// RL12: masks cleared by reset, kept by stop
// RL13: recovery off: underflow turns transmitter off
// RL14: recovery on: underflow rescans ring, restarts
// RL15: recovery bit always accessible, reset-register read clears
// RL16: reserved mask bits written zero, read zero
// RL17: masks at bits 14, 12, 11, 10
// RL18: irq when enable and summary both set
// RL19: host loads index before every access
// RL20: address writes ignored unless stopped/suspended
module init_irq_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  reg_port_if.device port,
  // controller state from the surrounding core
  input wire logic stop_i,
  input wire logic suspend_i,
  input wire logic irq_output_enable_i,
  input wire logic tx_start_i,
  // event sources and flag clears
  input wire init_irq_pkg::event_vec_t event_set_i,
  input wire init_irq_pkg::event_vec_t event_clear_i,
  input wire logic tx_fifo_underflow_error_i,
  // results towards the core and the bus
  output logic [23:0] init_block_addr_o,
  output logic [15:0] init_addr_low_shadow_o,
  output logic [15:0] init_addr_high_shadow_o,
  output init_irq_pkg::event_vec_t event_flags_o,
  output init_irq_pkg::event_vec_t irq_masks_o,
  output logic underflow_recover_enable_o,
  output logic irq_summary_flag_o,
  output logic irq_o,
  output logic transmitter_on_status_o,
  output logic ring_rescan_o
);
  import init_irq_pkg::*;

  // ========================================================================
  // storage
  logic [6:0] reg_index;          // selected register number
  logic [15:0] addr_low;          // address bits 15-0, bit 0 kept zero
  logic [7:0] addr_high;          // address bits 23-16
  logic [15:0] shadow_low;        // copy of last accepted low write
  logic [15:0] shadow_high;       // copy of last accepted high write
  event_vec_t flags;              // sticky event flags
  event_vec_t masks;              // one bit per event, 1 blocks the summary
  logic tx_fifo_underflow_error_recover;             // 1: ride through underflow
  logic summary;                  // registered summary flag
  logic irq;                      // registered request output
  logic tx_on;                    // transmitter running
  logic rescan;                   // one-cycle ring rescan request
  logic [15:0] rdata;             // registered read data
  logic rdata_valid;              // registered read strobe

  // ========================================================================
  // decoding
  wire addr_open = stop_i | suspend_i;                                      // [RL3]
  wire wr_low = port.data_wr & (reg_index == IDX_ADDR_LOW) & addr_open;    // [RL20]
  wire wr_high = port.data_wr & (reg_index == IDX_ADDR_HIGH) & addr_open;  // [RL20]
  wire wr_masks = port.data_wr & (reg_index == IDX_MASKS);
  wire rd_reset_reg = port.data_rd & (reg_index == IDX_RESET_REG);
  // software must keep bit 0 at zero; the hardware forces it anyway
  wire [15:0] low_value = {port.wdata[15:1], 1'b0};                         // [RL1]
  // the reserved upper byte is dropped, so it always reads back zero
  wire [15:0] high_value = {8'h00, port.wdata[7:0]};                        // [RL4]
  wire event_vec_t wr_mask_bits = pick_events(port.wdata);                  // [RL17]
  // a flag whose set and clear meet in one cycle stays set
  wire event_vec_t next_flags = stop_i ? 6'h00 : (flags & ~event_clear_i) | event_set_i;
  // masked events are still recorded in flags, they only miss the summary
  wire event_vec_t live_events = next_flags & ~masks;                      // [RL6] [RL7] [RL8]
  wire next_summary = |live_events;                                         // [RL9] [RL10] [RL11]
  wire tx_fifo_underflow_error_stop = tx_fifo_underflow_error_i & ~tx_fifo_underflow_error_recover;               // [RL13]
  wire tx_fifo_underflow_error_ride = tx_fifo_underflow_error_i & tx_fifo_underflow_error_recover;                // [RL14]
  wire next_tx_on = (stop_i | tx_fifo_underflow_error_stop) ? 1'b0 : (tx_on | tx_start_i);
  wire [15:0] status_word = place_events(flags)
                          | ({15'h0000, summary} << POS_SUMMARY)
                          | ({15'h0000, irq_output_enable_i} << POS_IRQ_EN)
                          | ({15'h0000, tx_on} << POS_TX_ON)
                          | ({15'h0000, suspend_i} << POS_SUSPEND)
                          | ({15'h0000, stop_i} << POS_STOP);
  // reserved mask bits answer zero, which is one of the allowed values
  wire [15:0] mask_word = place_events(masks)
                        | ({15'h0000, tx_fifo_underflow_error_recover} << POS_TX_FIFO_UNDERFLOW_ERROR_RECOVER); // [RL16]

  // read multiplexer; unknown indices answer zero
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = DATA_ZERO;
    unique case (reg_index)
      IDX_STATUS: next_rdata = status_word;
      IDX_ADDR_LOW: next_rdata = addr_open ? addr_low : DATA_ZERO;          // [RL3]
      IDX_ADDR_HIGH: next_rdata = addr_open ? {8'h00, addr_high} : DATA_ZERO; // [RL3]
      IDX_MASKS: next_rdata = mask_word;
      IDX_SHADOW_LOW: next_rdata = shadow_low;
      IDX_SHADOW_HIGH: next_rdata = shadow_high;
      default: next_rdata = DATA_ZERO;
    endcase
  end

  // ========================================================================
  // index port: every access goes to the register last selected
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_index <= INDEX_RESET;
    end else if (port.index_wr) begin
      reg_index <= port.wdata[6:0];                                         // [RL19]
    end
  end

  // ========================================================================
  // address words and shadows keep their value through reset, so they
  // have no reset branch; they read unknown until software loads them
  always_ff @(posedge clk_i) begin
    if (wr_low) begin
      addr_low <= low_value;                                                // [RL1]
      shadow_low <= low_value;                                              // [RL2]
    end
    if (wr_high) begin
      addr_high <= high_value[7:0];                                         // [RL4]
      shadow_high <= high_value;                                            // [RL5]
    end
  end

  // ========================================================================
  // masks: only reset clears them, stop leaves them alone
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      masks <= MASKS_RESET;                                                 // [RL12]
    end else if (wr_masks) begin
      masks <= wr_mask_bits;                                                // [RL17]
    end
  end

  // ========================================================================
  // recovery control: writable at any time, cleared by the reset register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_fifo_underflow_error_recover <= TX_FIFO_UNDERFLOW_ERROR_RECOVER_RESET;
    end else if (rd_reset_reg) begin
      tx_fifo_underflow_error_recover <= TX_FIFO_UNDERFLOW_ERROR_RECOVER_RESET;                                   // [RL15]
    end else if (wr_masks) begin
      tx_fifo_underflow_error_recover <= port.wdata[POS_TX_FIFO_UNDERFLOW_ERROR_RECOVER];                         // [RL15]
    end
  end

  // ========================================================================
  // flags, summary and request; the request lags the summary by nothing
  // because both are computed from the same next values
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags <= 6'h00;
      summary <= 1'b0;
      irq <= 1'b0;
    end else begin
      flags <= next_flags;
      summary <= next_summary;
      irq <= next_summary & irq_output_enable_i;                            // [RL18]
    end
  end

  // ========================================================================
  // transmitter state and underflow handling
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_on <= 1'b0;
      rescan <= 1'b0;
    end else begin
      tx_on <= next_tx_on;                                                  // [RL13]
      rescan <= tx_fifo_underflow_error_ride & ~stop_i;                                        // [RL14]
    end
  end

  // ========================================================================
  // read answer, one cycle after the read strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata <= DATA_ZERO;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= port.data_rd;
      if (port.data_rd) begin
        rdata <= next_rdata;
      end
    end
  end

  // ========================================================================
  // outputs
  assign port.rdata = rdata;
  assign port.rdata_valid = rdata_valid;
  assign init_block_addr_o = {addr_high, addr_low};
  assign init_addr_low_shadow_o = shadow_low;
  assign init_addr_high_shadow_o = shadow_high;
  assign event_flags_o = flags;
  assign irq_masks_o = masks;
  assign underflow_recover_enable_o = tx_fifo_underflow_error_recover;
  assign irq_summary_flag_o = summary;
  assign irq_o = irq;
  assign transmitter_on_status_o = tx_on;
  assign ring_rescan_o = rescan;

endmodule : init_irq_regs

// ---- verilog/reg_port_host.sv ----
`timescale 1ns/1ps
// ==========================================================================
// host end: turns one command into index load plus data access
module reg_port_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  reg_port_if.host port,
  // command side
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [6:0] cmd_index_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic cmd_ready_o,
  // answer side
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o
);
  import init_irq_pkg::*;

  // ========================================================================
  // state
  host_state_t state;             // sequencer state
  logic is_write;                 // latched command kind
  logic [15:0] data_hold;         // latched write data
  logic index_wr;                 // registered port strobes
  logic data_wr;
  logic data_rd;
  logic [15:0] wdata;
  logic ready;
  logic rsp_valid;
  logic [15:0] rsp_data;

  wire take = cmd_valid_i & ready;
  wire done_wr = (state == H_ACCESS) & is_write;
  wire done_rd = (state == H_WAIT) & port.rdata_valid;

  // next state; the index is always loaded before the data access
  host_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      H_IDLE: next_state = take ? H_INDEX : H_IDLE;
      H_INDEX: next_state = H_ACCESS;                                      // [RL19]
      H_ACCESS: next_state = is_write ? H_IDLE : H_WAIT;
      H_WAIT: next_state = port.rdata_valid ? H_IDLE : H_WAIT;
      default: next_state = H_IDLE;
    endcase
  end

  // ========================================================================
  // sequencer and registered strobes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= H_IDLE;
      is_write <= 1'b0;
      data_hold <= DATA_ZERO;
      index_wr <= 1'b0;
      data_wr <= 1'b0;
      data_rd <= 1'b0;
      wdata <= DATA_ZERO;
      ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= DATA_ZERO;
    end else begin
      state <= next_state;
      index_wr <= take;                                                     // [RL19]
      data_wr <= (state == H_INDEX) & is_write;
      data_rd <= (state == H_INDEX) & ~is_write;
      ready <= (next_state == H_IDLE);
      rsp_valid <= done_wr | done_rd;
      if (take) begin
        is_write <= cmd_write_i;
        data_hold <= cmd_wdata_i;
        wdata <= {9'h000, cmd_index_i};
      end else if (state == H_INDEX) begin
        wdata <= data_hold;
      end
      if (done_rd) begin
        rsp_data <= port.rdata;
      end
    end
  end

  // ========================================================================
  // outputs
  assign port.index_wr = index_wr;
  assign port.data_wr = data_wr;
  assign port.data_rd = data_rd;
  assign port.wdata = wdata;
  assign cmd_ready_o = ready;
  assign rsp_valid_o = rsp_valid;
  assign rsp_data_o = rsp_data;

endmodule : reg_port_host

// ---- testbench/init_irq_regs_sva.sv ----
`timescale 1ns/1ps
// ==========================================================================
// register port checks: strobe order, answer timing, fixed read values
module init_irq_regs_sva
  import init_irq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic index_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rdata_valid
);
  logic [6:0] idx; // index as the device holds it
  wire mapped; // index that may read back nonzero
  assign mapped = (idx == IDX_STATUS) || (idx == IDX_ADDR_LOW) || (idx == IDX_ADDR_HIGH)
    || (idx == IDX_MASKS) || (idx == IDX_SHADOW_LOW) || (idx == IDX_SHADOW_HIGH);

  // ========================================================================
  // shadow of the index port; cleared by reset like the device copy
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx <= INDEX_RESET;
    end else if (index_wr) begin
      idx <= wdata[6:0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ========================================================================
  // assertions
  rd_answer_a: assert property (data_rd |=> rdata_valid)
    else $error("read strobe got no data pulse");
  no_stray_valid_a: assert property (rdata_valid |-> $past(data_rd))
    else $error("data pulse without a read");
  one_strobe_a: assert property ($onehot0({index_wr, data_wr, data_rd}))
    else $error("two port strobes at once");
  index_first_a: assert property ((data_wr || data_rd) |-> $past(index_wr))
    else $error("access not preceded by index load");
  low_bit0_a: assert property (rdata_valid && idx == IDX_ADDR_LOW |-> !rdata[0])
    else $error("low address bit 0 read as one");
  high_upper_a: assert property (rdata_valid && idx == IDX_ADDR_HIGH
    |-> rdata[15:8] == 8'h00)
    else $error("high address upper byte not zero");
  shadow_bit0_a: assert property (rdata_valid && idx == IDX_SHADOW_LOW |-> !rdata[0])
    else $error("low shadow bit 0 read as one");
  reset_reg_a: assert property (rdata_valid && !mapped |-> rdata == 16'h0000)
    else $error("reset or unmapped index read nonzero");
  rdata_hold_a: assert property (!rdata_valid |-> $stable(rdata))
    else $error("read data moved without a read");
endmodule : init_irq_regs_sva

// ---- testbench/test_init_irq_regs.sv ----
`timescale 1ns/1ps
// ==========================================================================
// both ends joined through the port; bench drives commands and events
module test_init_irq_regs;
  import init_irq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic stop_i = 1'b0;
  logic suspend_i = 1'b0;
  logic irq_en = 1'b1;
  logic tx_start = 1'b0;
  logic tx_fifo_underflow_error = 1'b0;
  event_vec_t ev_set = 6'h00;
  event_vec_t ev_clr = 6'h00;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [6:0] cmd_index = 7'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_ready, rsp_valid, summary, irq, tx_on, rescan, recover;
  logic [15:0] rsp_data, sh_low, sh_high, rd_val;
  logic [23:0] addr;
  event_vec_t flags, masks;
  int err_count = 0;
  int n_checks = 0;

  // ========================================================================
  // clock, port and the two ends
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  reg_port_if reg_port_if_inst ();
  reg_port_host reg_port_host_inst (.clk_i(clk_i), .rst_i(rst_i), .port(reg_port_if_inst.host),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_index_i(cmd_index),
    .cmd_wdata_i(cmd_wdata), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data));
  init_irq_regs init_irq_regs_inst (.clk_i(clk_i), .rst_i(rst_i),
    .port(reg_port_if_inst.device), .stop_i(stop_i), .suspend_i(suspend_i),
    .irq_output_enable_i(irq_en), .tx_start_i(tx_start), .event_set_i(ev_set),
    .event_clear_i(ev_clr), .tx_fifo_underflow_error_i(tx_fifo_underflow_error), .init_block_addr_o(addr),
    .init_addr_low_shadow_o(sh_low), .init_addr_high_shadow_o(sh_high),
    .event_flags_o(flags), .irq_masks_o(masks), .underflow_recover_enable_o(recover),
    .irq_summary_flag_o(summary), .irq_o(irq), .transmitter_on_status_o(tx_on),
    .ring_rescan_o(rescan));
  init_irq_regs_sva init_irq_regs_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
    .index_wr(reg_port_if_inst.index_wr), .data_wr(reg_port_if_inst.data_wr),
    .data_rd(reg_port_if_inst.data_rd), .wdata(reg_port_if_inst.wdata),
    .rdata(reg_port_if_inst.rdata), .rdata_valid(reg_port_if_inst.rdata_valid));

  // ========================================================================
  // compare, command and pulse helpers; all driving is at falling edges
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // one command, waits for the answer pulse; bounded so a hang is seen
  task automatic do_cmd(input logic wr, input logic [6:0] idx, input logic [15:0] d);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_index = idx;
    cmd_wdata = d;
    @(negedge clk_i);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    rd_val = rsp_data;
    chk_bit(rsp_valid, 1'b1);
  endtask : do_cmd
  // one-cycle event or clear pulse on event i
  task automatic pulse_ev(input int i, input logic clr);
    if (clr) begin
      ev_clr[i] = 1'b1;
    end else begin
      ev_set[i] = 1'b1;
    end
    @(negedge clk_i);
    ev_set = 6'h00;
    ev_clr = 6'h00;
  endtask : pulse_ev

  // ========================================================================
  // scenarios
  task automatic t_addr();
    stop_i = 1'b1;
    do_cmd(1'b1, IDX_ADDR_LOW, 16'ha5a4);
    do_cmd(1'b1, IDX_ADDR_HIGH, 16'h00c3);
    chk_word(addr, 24'hc3a5a4);
    chk_word(sh_low, 16'ha5a4);
    chk_word(sh_high, 16'h00c3);
    do_cmd(1'b0, IDX_ADDR_HIGH, 16'h0000);
    chk_word(rd_val, 16'h00c3);
    do_cmd(1'b0, IDX_SHADOW_LOW, 16'h0000);
    chk_word(rd_val, 16'ha5a4);
    stop_i = 1'b0;
    do_cmd(1'b1, IDX_ADDR_LOW, 16'h1110);
    chk_word(addr, 24'hc3a5a4);
    chk_word(sh_low, 16'ha5a4);
    do_cmd(1'b0, IDX_ADDR_LOW, 16'h0000);
    chk_word(rd_val, 16'h0000);
    suspend_i = 1'b1;
    do_cmd(1'b1, IDX_ADDR_HIGH, 16'h0042);
    chk_word(addr, 24'h42a5a4);
    suspend_i = 1'b0;
    // shadows stay readable while the controller runs
    do_cmd(1'b0, IDX_SHADOW_HIGH, 16'h0000);
    chk_word(rd_val, 16'h0042);
    $display("test addr done");
  endtask : t_addr
  task automatic t_masks();
    int pos[6] = '{POS_INIT_DONE, POS_TX_DONE, POS_RX_DONE, POS_MEMERR, POS_MISSED, POS_BABBLE};
    for (int i = 0; i < 6; i++) begin
      do_cmd(1'b1, IDX_MASKS, 16'h0001 << pos[i]);
      do_cmd(1'b0, IDX_MASKS, 16'h0000);
      chk_word(rd_val, 16'h0001 << pos[i]);
      chk_word(masks, 6'h01 << i);
      pulse_ev(i, 1'b0);
      chk_bit(flags[i], 1'b1);
      chk_bit(summary, 1'b0);
      chk_bit(irq, 1'b0);
      pulse_ev(i, 1'b1);
      do_cmd(1'b1, IDX_MASKS, 16'h0000);
      pulse_ev(i, 1'b0);
      chk_bit(irq, 1'b1);
      pulse_ev(i, 1'b1);
      chk_bit(summary, 1'b0);
    end
    irq_en = 1'b0;
    pulse_ev(EV_BABBLE, 1'b0);
    chk_bit(summary, 1'b1);
    chk_bit(irq, 1'b0);
    // status view: babble at bit 14, summary at bit 7, enable bit 6 low
    do_cmd(1'b0, IDX_STATUS, 16'h0000);
    chk_word(rd_val, 16'h4080);
    pulse_ev(EV_BABBLE, 1'b1);
    irq_en = 1'b1;
    $display("test masks done");
  endtask : t_masks
  task automatic t_tx_fifo_underflow_error();
    tx_start = 1'b1;
    @(negedge clk_i);
    tx_start = 1'b0;
    tx_fifo_underflow_error = 1'b1;
    @(negedge clk_i);
    tx_fifo_underflow_error = 1'b0;
    chk_bit(tx_on, 1'b0);
    chk_bit(rescan, 1'b0);
    do_cmd(1'b1, IDX_MASKS, 16'h4040);
    chk_bit(recover, 1'b1);
    tx_start = 1'b1;
    @(negedge clk_i);
    tx_start = 1'b0;
    tx_fifo_underflow_error = 1'b1;
    @(negedge clk_i);
    tx_fifo_underflow_error = 1'b0;
    chk_bit(rescan, 1'b1);
    chk_bit(tx_on, 1'b1);
    stop_i = 1'b1;
    @(negedge clk_i);
    stop_i = 1'b0;
    chk_word(masks, 6'h20);
    chk_bit(recover, 1'b1);
    do_cmd(1'b0, IDX_RESET_REG, 16'h0000);
    chk_bit(recover, 1'b0);
    $display("test underflow done");
  endtask : t_tx_fifo_underflow_error
  task automatic t_reset();
    // recovery and babble mask set first, so the reset has something to clear
    do_cmd(1'b1, IDX_MASKS, 16'h4040);
    chk_bit(recover, 1'b1);
    rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    chk_word(masks, 6'h00);
    chk_bit(recover, 1'b0);
    chk_word(addr, 24'h42a5a4);
    $display("test reset done");
  endtask : t_reset

  // ========================================================================
  // verdict, sequence and watchdog
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    chk_word(masks, 6'h00);
    t_addr();
    t_masks();
    t_tx_fifo_underflow_error();
    t_reset();
    stop_test();
  end
  // about 140 cycles expected; allow nearly thirty times that
  initial begin
    #80us;
    err_count++;
    stop_test();
  end
endmodule : test_init_irq_regs
